// ---- pkg/eps_pkg.sv ----
// eps_pkg: offsets, reset values, field layouts and types of the pwm stage
// assumes an 8-bit register port with a 4-bit word address
package eps_pkg;

    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 8;

    // register offsets
    localparam logic [3:0] PERIOD_REGISTER_OFS      = 4'h0;
    localparam logic [3:0] PERIOD_TIMER_OFS         = 4'h1;
    localparam logic [3:0] PWM_CONTROL_REG_OFS      = 4'h2;
    localparam logic [3:0] DUTY_HIGH_BYTE_OFS       = 4'h3;
    localparam logic [3:0] PERIPHERAL_FLAG_REG_OFS  = 4'h4;
    localparam logic [3:0] PERIOD_TIMER_CONTROL_OFS = 4'h5;
    localparam logic [3:0] PIN_DIRECTION_OFS        = 4'h6;
    localparam logic [3:0] PWM_SHUTDOWN_CONTROL_OFS = 4'h7;
    localparam logic [3:0] RESTART_CONTROL_OFS      = 4'h8;

    // reset values
    localparam logic [7:0] PERIOD_REGISTER_RST      = 8'hFF;
    localparam logic [7:0] PERIOD_TIMER_RST         = 8'h00;
    localparam logic [7:0] PWM_CONTROL_REG_RST      = 8'h00;
    localparam logic [7:0] DUTY_HIGH_BYTE_RST       = 8'h00;
    localparam logic [7:0] PERIOD_TIMER_CONTROL_RST = 8'h00;
    localparam logic [3:0] PIN_DIRECTION_RST        = 4'hF;
    localparam logic [7:0] PWM_SHUTDOWN_CONTROL_RST = 8'h00;

    // field positions
    localparam int unsigned FLAG_MATCH_BIT   = 1;
    localparam int unsigned TMR_RUN_BIT      = 2;
    localparam int unsigned RESTART_EN_BIT   = 7;
    localparam int unsigned DUTY_LOW_LSB     = 4;
    localparam int unsigned SD_STATUS_BIT    = 7;
    localparam int unsigned SD_RSV_BIT       = 5;
    localparam logic [1:0]  PWM_MODE_PREFIX  = 2'h3;

    // prescaler terminal counts
    localparam logic [3:0] PRESC_LAST_DIV1  = 4'h0;
    localparam logic [3:0] PRESC_LAST_DIV4  = 4'h3;
    localparam logic [3:0] PRESC_LAST_DIV16 = 4'hF;
    localparam logic [1:0] SUB_LAST         = 2'h3;

    typedef enum logic [1:0] {
        EPS_DIV1  = 2'b00,
        EPS_DIV4  = 2'b01,
        EPS_DIV16 = 2'b10,
        EPS_DIVX  = 2'b11
    } eps_presc_e;

    // shutdown control register layout, msb first
    typedef struct packed {
        logic       shutdown_status;
        logic       int_pin_source_enable;
        logic       unused;
        logic       port4_source_enable;
        logic [1:0] pair_ac_off_state;
        logic [1:0] pair_bd_off_state;
    } eps_sdctl_s;

    // one bit per output, a in bit 0
    typedef struct packed {
        logic d;
        logic c;
        logic b;
        logic a;
    } eps_pins_s;

endpackage

// ---- src/eps_pwm.sv ----
// eps_pwm: enhanced pwm output stage with level-based auto-shutdown
// assumes synchronous pin inputs, an 8-bit register port and one 200 MHz clock
`timescale 1ns/100ps

module eps_pwm (
    input  wire logic                        core_clk_in,
    input  wire logic                        srst_in,
    input  wire logic                        clk_en_in,
    input  wire logic                        sleep_in,
    input  wire logic [eps_pkg::ADDR_W-1:0]  reg_addr_in,
    input  wire logic [eps_pkg::DATA_W-1:0]  reg_wdata_in,
    input  wire logic                        reg_wr_in,
    input  wire logic                        reg_rd_in,
    output logic      [eps_pkg::DATA_W-1:0]  reg_rdata_out,
    input  wire logic                        port_b_pin0_in,
    input  wire logic                        port_b_pin4_in,
    output eps_pkg::eps_pins_s               pin_out,
    output eps_pkg::eps_pins_s               pin_oe_n_out
);

    logic [7:0]          period_register_r;
    logic [7:0]          period_timer_r;
    logic [1:0]          sub_cnt_r;
    logic [3:0]          presc_cnt_r;
    logic [7:0]          pwm_control_reg_r;
    logic [7:0]          duty_high_byte_r;
    logic [9:0]          duty_latch_r;
    logic                period_match_flag_r;
    logic [7:0]          period_timer_control_r;
    logic [3:0]          pin_direction_r;
    eps_pkg::eps_sdctl_s sdctl_r;
    logic                auto_restart_enable_r;
    logic                wait_period_r;
    logic                pwm_level_r;
    logic [7:0]          rdata_r;

    logic                run_c;
    logic                tick_c;
    logic                wrap_c;
    logic                pwm_mode_c;
    logic                cond_c;
    logic                force_c;
    logic [3:0]          presc_last_c;
    logic [9:0]          base_c;
    logic [9:0]          base_next_c;
    logic [9:0]          duty_new_c;
    logic                wr_sd_c;
    logic                wr_flag_c;
    logic                wr_tmr_c;
    eps_pkg::eps_sdctl_s sd_wr_c;
    eps_pkg::eps_presc_e presc_sel_c;

    // frozen while clock enable is low or during sleep
    assign run_c       = clk_en_in && !sleep_in;
    assign presc_sel_c = eps_pkg::eps_presc_e'(period_timer_control_r[1:0]);
    assign pwm_mode_c  = (pwm_control_reg_r[3:2] == eps_pkg::PWM_MODE_PREFIX);
    assign base_c      = {period_timer_r, sub_cnt_r};
    assign base_next_c = base_c + 10'h001;
    assign duty_new_c  = {duty_high_byte_r,
                          pwm_control_reg_r[eps_pkg::DUTY_LOW_LSB +: 2]};
    assign sd_wr_c     = eps_pkg::eps_sdctl_s'(reg_wdata_in);
    assign wr_sd_c     = clk_en_in && reg_wr_in
                         && (reg_addr_in == eps_pkg::PWM_SHUTDOWN_CONTROL_OFS);
    assign wr_flag_c   = clk_en_in && reg_wr_in
                         && (reg_addr_in == eps_pkg::PERIPHERAL_FLAG_REG_OFS);
    assign wr_tmr_c    = clk_en_in && reg_wr_in
                         && (reg_addr_in == eps_pkg::PERIOD_TIMER_OFS);

    always_comb
    begin
        case (presc_sel_c)
            eps_pkg::EPS_DIV1:  presc_last_c = eps_pkg::PRESC_LAST_DIV1;
            eps_pkg::EPS_DIV4:  presc_last_c = eps_pkg::PRESC_LAST_DIV4;
            default:            presc_last_c = eps_pkg::PRESC_LAST_DIV16;
        endcase
    end

    assign tick_c = run_c && period_timer_control_r[eps_pkg::TMR_RUN_BIT]
                    && (presc_cnt_r == presc_last_c);
    assign wrap_c = tick_c && (sub_cnt_r == eps_pkg::SUB_LAST)
                    && (period_timer_r == period_register_r);

    // level-based shutdown condition, sources ored
    assign cond_c = (sdctl_r.int_pin_source_enable && !port_b_pin0_in)
                    || (sdctl_r.port4_source_enable && !port_b_pin4_in);
    assign force_c = cond_c || sdctl_r.shutdown_status || wait_period_r;

    // prescaler
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
            presc_cnt_r <= '0;
        else if (run_c && period_timer_control_r[eps_pkg::TMR_RUN_BIT])
        begin
            if (tick_c)
                presc_cnt_r <= '0;
            else
                presc_cnt_r <= presc_cnt_r + 4'h1;
        end
    end

    // 10-bit time base: timer with two low bits
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            period_timer_r <= eps_pkg::PERIOD_TIMER_RST;
            sub_cnt_r      <= '0;
        end
        else if (wr_tmr_c)
        begin
            period_timer_r <= reg_wdata_in;
            sub_cnt_r      <= '0;
        end
        else if (wrap_c)
        begin
            period_timer_r <= '0;
            sub_cnt_r      <= '0;
        end
        else if (tick_c)
        begin
            sub_cnt_r <= sub_cnt_r + 2'h1;
            if (sub_cnt_r == eps_pkg::SUB_LAST)
                period_timer_r <= period_timer_r + 8'h01;
        end
    end

    // duty double buffer and pwm level
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            duty_latch_r <= '0;
            pwm_level_r  <= 1'b0;
        end
        else if (clk_en_in && !pwm_mode_c)
            pwm_level_r <= 1'b0;
        else if (wrap_c)
        begin
            duty_latch_r <= duty_new_c;
            pwm_level_r  <= (duty_new_c != 10'h000);
        end
        else if (tick_c && (base_next_c == duty_latch_r))
            pwm_level_r <= 1'b0;
    end

    // period match flag, set wins over clear
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
            period_match_flag_r <= 1'b0;
        else if (wrap_c)
            period_match_flag_r <= 1'b1;
        else if (wr_flag_c)
            period_match_flag_r <= reg_wdata_in[eps_pkg::FLAG_MATCH_BIT];
    end

    // plain software registers
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            period_register_r      <= eps_pkg::PERIOD_REGISTER_RST;
            pwm_control_reg_r      <= eps_pkg::PWM_CONTROL_REG_RST;
            duty_high_byte_r       <= eps_pkg::DUTY_HIGH_BYTE_RST;
            period_timer_control_r <= eps_pkg::PERIOD_TIMER_CONTROL_RST;
            pin_direction_r        <= eps_pkg::PIN_DIRECTION_RST;
            auto_restart_enable_r  <= 1'b0;
        end
        else if (clk_en_in && reg_wr_in)
        begin
            if (reg_addr_in == eps_pkg::PERIOD_REGISTER_OFS)
                period_register_r <= reg_wdata_in;
            else if (reg_addr_in == eps_pkg::PWM_CONTROL_REG_OFS)
                pwm_control_reg_r <= reg_wdata_in;
            else if (reg_addr_in == eps_pkg::DUTY_HIGH_BYTE_OFS)
                duty_high_byte_r <= reg_wdata_in;
            else if (reg_addr_in == eps_pkg::PERIOD_TIMER_CONTROL_OFS)
                period_timer_control_r <= {5'h00, reg_wdata_in[2:0]};
            else if (reg_addr_in == eps_pkg::PIN_DIRECTION_OFS)
                pin_direction_r <= reg_wdata_in[3:0];
            else if (reg_addr_in == eps_pkg::RESTART_CONTROL_OFS)
                auto_restart_enable_r <= reg_wdata_in[eps_pkg::RESTART_EN_BIT];
        end
    end

    // shutdown control and sticky status
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
            sdctl_r <= eps_pkg::eps_sdctl_s'(eps_pkg::PWM_SHUTDOWN_CONTROL_RST);
        else if (clk_en_in)
        begin
            if (wr_sd_c)
            begin
                sdctl_r.int_pin_source_enable <= sd_wr_c.int_pin_source_enable;
                sdctl_r.port4_source_enable   <= sd_wr_c.port4_source_enable;
                sdctl_r.pair_ac_off_state     <= sd_wr_c.pair_ac_off_state;
                sdctl_r.pair_bd_off_state     <= sd_wr_c.pair_bd_off_state;
            end
            sdctl_r.unused <= 1'b0;
            if (cond_c)
                sdctl_r.shutdown_status <= 1'b1;
            else if (wr_sd_c)
                sdctl_r.shutdown_status <= sd_wr_c.shutdown_status;
            else if (auto_restart_enable_r)
                sdctl_r.shutdown_status <= 1'b0;
        end
    end

    // hold off the waveform until a fresh period begins
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
            wait_period_r <= 1'b0;
        else if (clk_en_in)
        begin
            if (cond_c || sdctl_r.shutdown_status)
                wait_period_r <= 1'b1;
            else if (wrap_c)
                wait_period_r <= 1'b0;
        end
    end

    // read port, data one cycle after the strobe
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
            rdata_r <= '0;
        else if (clk_en_in)
        begin
            rdata_r <= '0;
            if (reg_rd_in)
            begin
                if (reg_addr_in == eps_pkg::PERIOD_REGISTER_OFS)
                    rdata_r <= period_register_r;
                else if (reg_addr_in == eps_pkg::PERIOD_TIMER_OFS)
                    rdata_r <= period_timer_r;
                else if (reg_addr_in == eps_pkg::PWM_CONTROL_REG_OFS)
                    rdata_r <= pwm_control_reg_r;
                else if (reg_addr_in == eps_pkg::DUTY_HIGH_BYTE_OFS)
                    rdata_r <= duty_high_byte_r;
                else if (reg_addr_in == eps_pkg::PERIPHERAL_FLAG_REG_OFS)
                    rdata_r <= {6'h00, period_match_flag_r, 1'b0};
                else if (reg_addr_in == eps_pkg::PERIOD_TIMER_CONTROL_OFS)
                    rdata_r <= period_timer_control_r;
                else if (reg_addr_in == eps_pkg::PIN_DIRECTION_OFS)
                    rdata_r <= {4'h0, pin_direction_r};
                else if (reg_addr_in == eps_pkg::PWM_SHUTDOWN_CONTROL_OFS)
                    rdata_r <= sdctl_r;
                else if (reg_addr_in == eps_pkg::RESTART_CONTROL_OFS)
                    rdata_r <= {auto_restart_enable_r, 7'h00};
            end
        end
    end

    assign reg_rdata_out = rdata_r;

    // pin stage: a/c carry pwm, b/d its complement; shutdown overrides at once
    always_comb
    begin
        pin_out      = '0;
        pin_oe_n_out = pin_direction_r | {4{!pwm_mode_c}};
        if (force_c)
        begin
            pin_out.a      = sdctl_r.pair_ac_off_state[0];
            pin_out.c      = sdctl_r.pair_ac_off_state[0];
            pin_out.b      = sdctl_r.pair_bd_off_state[0];
            pin_out.d      = sdctl_r.pair_bd_off_state[0];
            pin_oe_n_out.a = pin_oe_n_out.a | sdctl_r.pair_ac_off_state[1];
            pin_oe_n_out.c = pin_oe_n_out.c | sdctl_r.pair_ac_off_state[1];
            pin_oe_n_out.b = pin_oe_n_out.b | sdctl_r.pair_bd_off_state[1];
            pin_oe_n_out.d = pin_oe_n_out.d | sdctl_r.pair_bd_off_state[1];
        end
        else
        begin
            pin_out.a = pwm_level_r;
            pin_out.c = pwm_level_r;
            pin_out.b = !pwm_level_r;
            pin_out.d = !pwm_level_r;
        end
    end

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (srst_in);

    sequence frozen_s;
        !run_c && !wr_tmr_c;
    endsequence

    sequence period_end_s;
        wrap_c && pwm_mode_c && !wr_tmr_c;
    endsequence

    timer_freeze_a: assert property (frozen_s |=> $stable(base_c))
        else $error("time base moved while frozen");

    period_wrap_a: assert property (period_end_s |=>
        (base_c == 10'h000) && period_match_flag_r
        && (pwm_level_r == ($past(duty_new_c) != 10'h000)))
        else $error("period match did not clear timer or set output");

    status_set_a: assert property (clk_en_in && cond_c |=> sdctl_r.shutdown_status)
        else $error("shutdown did not set status");

    force_low_a: assert property (cond_c && (sdctl_r.pair_ac_off_state == 2'b00)
        |-> !pin_out.a && !pin_out.c)
        else $error("pair a/c not forced low");

    tri_pair_a: assert property (force_c && sdctl_r.pair_bd_off_state[1]
        |-> pin_oe_n_out.b && pin_oe_n_out.d)
        else $error("pair b/d not released");

    write_ignore_a: assert property (cond_c && wr_sd_c && !sd_wr_c.shutdown_status
        |=> sdctl_r.shutdown_status)
        else $error("status cleared during active shutdown");

    auto_clear_a: assert property (clk_en_in && sdctl_r.shutdown_status && !cond_c
        && auto_restart_enable_r && !wr_sd_c |=> !sdctl_r.shutdown_status)
        else $error("auto restart did not clear status");

    resume_wait_a: assert property ($fell(sdctl_r.shutdown_status) && !wrap_c
        |-> force_c)
        else $error("waveform resumed before period start");

    reserved_zero_a: assert property (clk_en_in && reg_rd_in
        && (reg_addr_in == eps_pkg::PWM_SHUTDOWN_CONTROL_OFS)
        |=> !reg_rdata_out[eps_pkg::SD_RSV_BIT])
        else $error("reserved control bit read as one");

    reset_dir_a: assert property ($past(srst_in) |-> pin_direction_r == 4'hF)
        else $error("pins not inputs after reset");

endmodule

// ---- tb/eps_bridge_model.sv ----
// eps_bridge_model: bridge switches on the four pwm pins plus two shutdown sources
// assumes the bench commands faults; source lines idle high through pull-ups
`timescale 1ns/100ps
module eps_bridge_model (
    input  wire logic                clk_in,
    input  wire logic                fault_int_in,
    input  wire logic                fault_p4_in,
    input  wire eps_pkg::eps_pins_s  pin_in,
    input  wire eps_pkg::eps_pins_s  oe_n_in,
    output logic                     src_int_out,
    output logic                     src_p4_out,
    output logic      [3:0]          wire_out
);
    logic [3:0] last_r = 4'h0;

    // fault is a low level held while commanded
    assign src_int_out = ~fault_int_in;
    assign src_p4_out  = ~fault_p4_in;

    // remember the level each pin last drove
    always @(posedge clk_in)
    begin
        for (int i = 0; i < 4; i++)
        begin
            if (!oe_n_in[i])
                last_r[i] <= pin_in[i];
        end
    end

    // a released pin shows the inverse of its last driven level
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            wire_out[i] = oe_n_in[i] ? ~last_r[i] : pin_in[i];
        end
    end
endmodule

// ---- tb/eps_pwm_tb_top.sv ----
// eps_pwm_tb_top: register, waveform, sleep and shutdown scenarios for eps_pwm
// assumes the bridge model on the pins and reads compared from a queue
`timescale 1ns/100ps
module eps_pwm_tb_top;
    logic                        core_clk_in  = 1'b0;
    logic                        srst_in      = 1'b1;
    logic                        clk_en_in    = 1'b1;
    logic                        sleep_in     = 1'b0;
    logic [eps_pkg::ADDR_W-1:0]  reg_addr_in  = '0;
    logic [eps_pkg::DATA_W-1:0]  reg_wdata_in = '0;
    logic                        reg_wr_in    = 1'b0;
    logic                        reg_rd_in    = 1'b0;
    logic [eps_pkg::DATA_W-1:0]  reg_rdata_out;
    logic                        src_int;
    logic                        src_p4;
    eps_pkg::eps_pins_s          pin_out;
    eps_pkg::eps_pins_s          pin_oe_n_out;
    logic [3:0]                  wire_lvl;
    logic                        fault_int    = 1'b0;
    logic                        fault_p4     = 1'b0;
    logic                        rd_pend      = 1'b0;
    logic [7:0]                  exp_q[$];
    logic [31:0]                 lfsr         = 32'h77a4_98e5;
    logic [7:0]                  v;
    int                          num_errors   = 0;
    int                          cmp_count    = 0;
    int                          cyc          = 0;
    int                          hi;
    int                          bad;
    int                          dv;
    int                          win;
    int                          exp_hi;
    int tp[7] = '{0, 0, 0, 0, 0, 3, 255};
    int td[7] = '{2, 2, 2, 0, 5, 9, 1023};
    int tc[7] = '{0, 1, 2, 0, 0, 1, 0};
    logic [7:0] rstv[11] = '{8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0F, 8'h00,
                            8'h00, 8'h00, 8'h00};

    eps_pwm dut (
        .core_clk_in    (core_clk_in),
        .srst_in        (srst_in),
        .clk_en_in      (clk_en_in),
        .sleep_in       (sleep_in),
        .reg_addr_in    (reg_addr_in),
        .reg_wdata_in   (reg_wdata_in),
        .reg_wr_in      (reg_wr_in),
        .reg_rd_in      (reg_rd_in),
        .reg_rdata_out  (reg_rdata_out),
        .port_b_pin0_in (src_int),
        .port_b_pin4_in (src_p4),
        .pin_out        (pin_out),
        .pin_oe_n_out   (pin_oe_n_out)
    );

    eps_bridge_model bridge (
        .clk_in       (core_clk_in),
        .fault_int_in (fault_int),
        .fault_p4_in  (fault_p4),
        .pin_in       (pin_out),
        .oe_n_in      (pin_oe_n_out),
        .src_int_out  (src_int),
        .src_p4_out   (src_p4),
        .wire_out     (wire_lvl)
    );

    always #2.5 core_clk_in = ~core_clk_in;

    task automatic final_report();
        $display("compares %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            $display("ERROR %s expected %h seen %h", name, exp, seen);
            num_errors++;
        end
    endtask

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // bus tasks start right after an edge and leave one idle cycle
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        reg_wr_in    <= 1'b1;
        @(posedge core_clk_in);
        reg_wr_in    <= 1'b0;
        @(posedge core_clk_in);
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        reg_addr_in <= a;
        reg_rd_in   <= 1'b1;
        exp_q.push_back(e);
        @(posedge core_clk_in);
        reg_rd_in   <= 1'b0;
        @(posedge core_clk_in);
    endtask

    // high cycles of pin a, and cycles where c differs from a or b is not the complement of a
    task automatic count_hi(input int n, output int h, output int b);
        h = 0;
        b = 0;
        repeat (n)
        begin
            @(negedge core_clk_in);
            h += wire_lvl[0];
            b += (wire_lvl[2] !== wire_lvl[0]) || (wire_lvl[1] !== ~wire_lvl[0]);
        end
        @(posedge core_clk_in);
    endtask

    task automatic reset_check();
        srst_in <= 1'b1;
        repeat (2) @(posedge core_clk_in);
        srst_in <= 1'b0;
        @(negedge core_clk_in);
        check("pin_oe_n_out", pin_oe_n_out, 4'hF);
        @(posedge core_clk_in);
        for (int i = 0; i < 11; i++)
            rd((i == 10) ? 4'hF : i[3:0], rstv[i]);
    endtask

    // read data stand only in the cycle after the strobe
    always @(posedge core_clk_in)
    begin
        if (rd_pend)
            check("reg_rdata_out", reg_rdata_out, exp_q.pop_front());
        rd_pend <= reg_rd_in;
    end

    always @(posedge core_clk_in)
    begin
        cyc++;
        if (cyc > 60000)
        begin
            num_errors++;
            final_report();
        end
    end

    initial
    begin
        repeat (6) @(posedge core_clk_in);
        reset_check();
        repeat (4)
        begin
            lfsr = lfsr_next(lfsr);
            wr(4'h3, lfsr[7:0]);
            rd(4'h3, lfsr[7:0]);
        end
        // setup order: driver off, period, mode, duty, flag, prescale and run
        wr(4'h6, 8'h0F);
        wr(4'h0, 8'h00);
        wr(4'h2, 8'h2C);
        wr(4'h3, 8'h00);
        wr(4'h4, 8'h00);
        wr(4'h5, 8'h04);
        repeat (8) @(posedge core_clk_in);
        rd(4'h4, 8'h02);
        wr(4'h6, 8'h00);
        for (int k = 0; k < 7; k++)
        begin
            dv  = (tc[k] == 0) ? 1 : (tc[k] == 1) ? 4 : 16;
            win = 4 * (tp[k] + 1) * dv;
            wr(4'h0, tp[k][7:0]);
            wr(4'h3, td[k][9:2]);
            wr(4'h2, {2'b00, td[k][1:0], 4'hC});
            wr(4'h5, {5'b00000, 1'b1, tc[k][1:0]});
            repeat (2 * win + 40) @(posedge core_clk_in);
            exp_hi = (td[k] < 4 * (tp[k] + 1)) ? td[k] * dv : win;
            count_hi(win, hi, bad);
            check("high_cycles", hi, exp_hi);
            check("pair_mismatch", bad, 0);
            count_hi(win, hi, bad);
            check("high_cycles", hi, exp_hi);
            check("pair_mismatch", bad, 0);
        end
        // sleep holds timer and level; writes still taken
        wr(4'h1, 8'hFF);
        repeat (3) @(posedge core_clk_in);
        wr(4'h5, 8'h00);
        wr(4'h1, 8'h10);
        sleep_in <= 1'b1;
        wr(4'h5, 8'h04);
        count_hi(40, hi, bad);
        check("sleep_level", hi, 40);
        rd(4'h1, 8'h10);
        sleep_in <= 1'b0;
        rd(4'h1, 8'h10);
        clk_en_in <= 1'b0;
        wr(4'h0, 8'h55);
        clk_en_in <= 1'b1;
        rd(4'h0, 8'hFF);
        wr(4'h0, 8'h00);
        wr(4'h1, 8'h00);
        wr(4'h3, 8'h00);
        wr(4'h2, 8'h2C);
        for (int c = 0; c < 4; c++)
        begin
            v = {4'h8, c[1:0], c[1:0]};
            wr(4'h7, v);
            @(negedge core_clk_in);
            check("pin_oe_n_out", pin_oe_n_out, c[1] ? 4'hF : 4'h0);
            if (!c[1])
                check("pin_wire", wire_lvl, c[0] ? 4'hF : 4'h0);
            @(posedge core_clk_in);
            rd(4'h7, v);
            wr(4'h7, 8'h00);
        end
        wr(4'h7, 8'h44);
        fault_int <= 1'b1;
        @(negedge core_clk_in);
        check("pin_wire", wire_lvl, 4'h5);
        @(posedge core_clk_in);
        count_hi(20, hi, bad);
        check("forced_high", hi + bad, 20);
        rd(4'h7, 8'hC4);
        wr(4'h7, 8'h44);
        rd(4'h7, 8'hC4);
        fault_int <= 1'b0;
        repeat (8) @(posedge core_clk_in);
        rd(4'h7, 8'hC4);
        wr(4'h7, 8'h44);
        rd(4'h7, 8'h44);
        count_hi(8, hi, bad);
        count_hi(8, hi, bad);
        check("resumed_high", hi, 4);
        wr(4'h8, 8'h80);
        wr(4'h7, 8'h40);
        fault_p4 <= 1'b1;
        repeat (4) @(posedge core_clk_in);
        rd(4'h7, 8'h40);
        fault_int <= 1'b1;
        @(negedge core_clk_in);
        check("pin_wire", wire_lvl, 4'h0);
        @(posedge core_clk_in);
        fault_int <= 1'b0;
        repeat (4) @(posedge core_clk_in);
        wr(4'h7, 8'h1A);
        @(negedge core_clk_in);
        check("pin_oe_n_out", pin_oe_n_out, 4'hF);
        @(posedge core_clk_in);
        rd(4'h7, 8'h9A);
        fault_p4 <= 1'b0;
        repeat (4) @(posedge core_clk_in);
        rd(4'h7, 8'h1A);
        fault_int <= 1'b1;
        reset_check();
        fault_int <= 1'b0;
        repeat (2) @(posedge core_clk_in);
        final_report();
    end
endmodule
